// File: bcl_pkg.sv
// Purpose: Shared constants and types of the boot configuration loader
// Assumes: Byte wide flash reads, 16-bit register bus
// Notes:   Register offsets are byte addresses on the local port

// ********************************************************
// Package
// ********************************************************
package bcl_pkg;
  localparam int          AW          = 17;
  localparam logic [16:0] CFG_BASE    = 17'h00004;
  localparam logic [16:0] CFG_COUNT   = 17'h0001C;
  localparam logic [16:0] HDR_COUNT   = 17'h00008;
  localparam logic [1:0]  STRAP_WAIT  = 2'h2;
  localparam logic [4:0]  OFS_SIG0    = 5'h04;
  localparam logic [4:0]  OFS_SIG1    = 5'h05;
  localparam logic [4:0]  OFS_SIG2    = 5'h06;
  localparam logic [4:0]  OFS_SIG3    = 5'h07;
  localparam logic [4:0]  OFS_LEN     = 5'h08;
  localparam logic [4:0]  OFS_PAGE    = 5'h0A;
  localparam logic [4:0]  OFS_HPTR    = 5'h0C;
  localparam logic [4:0]  OFS_MODULE_CONFIG_REG    = 5'h0E;
  localparam logic [4:0]  OFS_BUSIF   = 5'h10;
  localparam logic [4:0]  OFS_IOZ     = 5'h12;
  localparam logic [4:0]  OFS_SZ0     = 5'h14;
  localparam logic [4:0]  OFS_BZ      = 5'h16;
  localparam logic [4:0]  OFS_PE      = 5'h18;
  localparam logic [7:0]  CFG_SIG0    = 8'hE3;
  localparam logic [7:0]  CFG_SIG1    = 8'h8E;
  localparam logic [7:0]  CFG_SIG2    = 8'h1C;
  localparam logic [7:0]  CFG_SIG3    = 8'h71;
  localparam logic [7:0]  CFG_LEN     = 8'h16;
  localparam logic [7:0]  HDR_SIG0    = 8'h33;
  localparam logic [7:0]  HDR_SIG1    = 8'hCC;
  localparam logic [7:0]  SIZE_BAD    = 8'hFF;
  localparam logic [15:0] LABEL_NONE  = 16'hFFFF;
  localparam logic [15:0] MODULE_CONFIG_REG_MASK   = 16'h0007;
  localparam int          MODULE_CONFIG_REG_BUS16  = 3;
  localparam int          ZONE_BW     = 7;
  localparam logic [15:0] CFG_RST     = 16'h0000;
  localparam logic [15:0] RAM_VAR_LO  = 16'hF000;
  localparam logic [15:0] RAM_TBL_LO  = 16'hF010;
  localparam logic [15:0] RAM_USER_LO = 16'hF070;
  localparam logic [15:0] RAM_STK_LO  = 16'hF3C0;
  localparam logic [7:0]  CMD_LOAD    = 8'h90;
  localparam logic [7:0]  CMD_STAT    = 8'h92;
  localparam logic [7:0]  CMD_TEST    = 8'hAA;
  localparam logic [7:0]  RSP_ACK     = 8'hFA;
  localparam logic [7:0]  RSP_ERR     = 8'hFF;
  localparam logic [7:0]  REG_STATUS  = 8'h00;
  localparam logic [7:0]  REG_MODULE_CONFIG_REG    = 8'h04;
  localparam logic [7:0]  REG_BUSIF   = 8'h08;
  localparam logic [7:0]  REG_IOZ     = 8'h0C;
  localparam logic [7:0]  REG_SZ0     = 8'h10;
  localparam logic [7:0]  REG_BZ      = 8'h14;
  localparam logic [7:0]  REG_PE      = 8'h18;
  localparam logic [7:0]  REG_PAGE    = 8'h1C;
  localparam logic [7:0]  REG_CTRL    = 8'h20;
  localparam logic [7:0]  REG_HCMD    = 8'h24;
  localparam logic [7:0]  REG_HRSP    = 8'h28;

  typedef enum logic [3:0] {
    ST_STRAP   = 4'h0,
    ST_CFG     = 4'h1,
    ST_CFG_CHK = 4'h2,
    ST_LOAD    = 4'h3,
    ST_HDR     = 4'h4,
    ST_HDR_CHK = 4'h5,
    ST_SUM     = 4'h6,
    ST_SUM_CHK = 4'h7,
    ST_CRISIS  = 4'h8,
    ST_BOOT    = 4'h9,
    ST_FAIL    = 4'hA
  } bcl_state_type;

  typedef enum logic [1:0] {
    C_IDLE = 2'h0,
    C_ARG  = 2'h1,
    C_DATA = 2'h2
  } bcl_cmd_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } bcl_mem_rsp_type;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } bcl_ram_wr_type;
endpackage

// File: bcl_boot_config_loader.sv
// Purpose: Hardware boot sequencer: config block, header, checksum
// Assumes: Flash answers each read at least one cycle after request
// Notes:   Recovery command service runs only after a failed boot
//
// How it works
// - Strap sampled, merged with config block
// - Config block fetched from 0004h-001Fh
// - Bytes 4,5 must be E3h, 8Eh
// - Bytes 6,7 must be 1Ch, 71h
// - Byte 8 length must be 22
// - Page at 10, header pointer at 12
// - Module config copies three bits only
// - Bus, io zone, port E loaded
// - Static zone width from strap pin
// - Boot zone width forced 16-bit
// - Every entry is a 16-bit slot
// - No checksum over config block
// - Header signature 33h then CCh
// - Size zero or FFh rejected
// - Size counts 256-byte units
// - Header plus code must sum zero
// - Label FFFFh skips integrity routine
// - Code label shifted left gives address
// - Strap 0 means 8-bit, 1 16-bit
// - Indicator high on success, low failing
// - Recovery commands accepted when boot fails
// - Loader RAM areas protected from loads
// - Bad config signature enters failure loop
// - Load RAM takes range, answers FAh/FFh
// - Self test answered with FFh
`timescale 1ns/100ps

module bcl_boot_config_loader (
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  input  wire logic [7:0]               bus_addr,
  input  wire logic [15:0]              bus_wdata,
  input  wire logic                     bus_wr,
  input  wire logic                     bus_rd,
  output logic      [15:0]              bus_rdata,
  output logic                          mem_rd_req,
  output logic      [16:0]              mem_rd_addr,
  input  wire bcl_pkg::bcl_mem_rsp_type mem_rsp,
  input  wire logic                     bus_width_strap_pin,
  output logic                          boot_ok_indicator_pin,
  output logic                          crisis_req,
  output logic      [16:0]              crisis_addr,
  input  wire logic                     crisis_done,
  input  wire logic                     crisis_zero,
  output logic      [16:0]              fw_entry_addr,
  output logic                          fw_start,
  output bcl_pkg::bcl_ram_wr_type       ram_wr
);

  // ********************************************************
  // State and storage
  // ********************************************************
  bcl_pkg::bcl_state_type st_r;
  bcl_pkg::bcl_state_type st_nxt;
  bcl_pkg::bcl_cmd_type   cst_r;
  logic [7:0]             cfg_mem [0:31];
  logic [63:0]            hdr_r;
  logic [16:0]            rd_addr_r;
  logic [16:0]            cnt_r;
  logic                   pend_r;
  logic [7:0]             sum_r;
  logic                   strap_s1_r;
  logic                   strap_s2_r;
  logic                   bus16_r;
  logic [1:0]             wait_r;
  logic [15:0]            module_config_reg_r;
  logic [15:0]            busif_r;
  logic [15:0]            ioz_r;
  logic [15:0]            sz0_r;
  logic [15:0]            bz_r;
  logic [15:0]            pe_r;
  logic [15:0]            page_r;
  logic                   fail_cfg_r;
  logic                   fail_fw_r;
  logic                   fail_crisis_r;
  logic                   boot_ok_r;
  logic                   fw_start_r;
  logic [16:0]            entry_r;
  logic [16:0]            crisis_addr_r;
  logic [15:0]            rdata_r;
  logic [31:0]            arg_r;
  logic [1:0]             acnt_r;
  logic [15:0]            dcnt_r;
  logic [15:0]            ram_ptr_r;
  logic                   ok_r;
  logic [7:0]             resp_r;
  logic                   resp_v_r;
  bcl_pkg::bcl_ram_wr_type ram_wr_r;

  // ********************************************************
  // Decode
  // ********************************************************
  wire fetching = (st_r == bcl_pkg::ST_CFG) ||
                  (st_r == bcl_pkg::ST_HDR) ||
                  (st_r == bcl_pkg::ST_SUM);
  wire take     = mem_rsp.valid && pend_r;
  wire last     = take && (cnt_r == 17'h00001);
  wire strap_go = (st_r == bcl_pkg::ST_STRAP) &&
                  (wait_r == bcl_pkg::STRAP_WAIT);

  // Each entry is a low/high byte pair in its own slot
  wire [15:0] w_module_config_reg  = {cfg_mem[bcl_pkg::OFS_MODULE_CONFIG_REG + 5'h01],
                         cfg_mem[bcl_pkg::OFS_MODULE_CONFIG_REG]};
  wire [15:0] w_busif = {cfg_mem[bcl_pkg::OFS_BUSIF + 5'h01],
                         cfg_mem[bcl_pkg::OFS_BUSIF]};
  wire [15:0] w_ioz   = {cfg_mem[bcl_pkg::OFS_IOZ + 5'h01],
                         cfg_mem[bcl_pkg::OFS_IOZ]};
  wire [15:0] w_sz0   = {cfg_mem[bcl_pkg::OFS_SZ0 + 5'h01],
                         cfg_mem[bcl_pkg::OFS_SZ0]};
  wire [15:0] w_bz    = {cfg_mem[bcl_pkg::OFS_BZ + 5'h01],
                         cfg_mem[bcl_pkg::OFS_BZ]};
  wire [15:0] w_pe    = {cfg_mem[bcl_pkg::OFS_PE + 5'h01],
                         cfg_mem[bcl_pkg::OFS_PE]};
  wire [15:0] w_page  = {cfg_mem[bcl_pkg::OFS_PAGE + 5'h01],
                         cfg_mem[bcl_pkg::OFS_PAGE]};
  wire [15:0] w_hptr  = {cfg_mem[bcl_pkg::OFS_HPTR + 5'h01],
                         cfg_mem[bcl_pkg::OFS_HPTR]};

  wire cfg_ok =
    (cfg_mem[bcl_pkg::OFS_SIG0] == bcl_pkg::CFG_SIG0) &&
    (cfg_mem[bcl_pkg::OFS_SIG1] == bcl_pkg::CFG_SIG1) &&
    (cfg_mem[bcl_pkg::OFS_SIG2] == bcl_pkg::CFG_SIG2) &&
    (cfg_mem[bcl_pkg::OFS_SIG3] == bcl_pkg::CFG_SIG3) &&
    (cfg_mem[bcl_pkg::OFS_LEN] == bcl_pkg::CFG_LEN);

  // Header bytes shift in from the bottom; byte 0 ends on top
  wire [7:0]  h_sig0  = hdr_r[63:56];
  wire [7:0]  h_sig1  = hdr_r[55:48];
  wire [7:0]  h_size  = hdr_r[47:40];
  wire [15:0] h_label = {hdr_r[23:16], hdr_r[31:24]};
  wire [15:0] h_entry = {hdr_r[7:0], hdr_r[15:8]};
  wire size_bad = (h_size == 8'h00) ||
                  (h_size == bcl_pkg::SIZE_BAD);
  wire hdr_ok   = (h_sig0 == bcl_pkg::HDR_SIG0) &&
                  (h_sig1 == bcl_pkg::HDR_SIG1) &&
                  !size_bad;
  wire no_label = (h_label == bcl_pkg::LABEL_NONE);

  wire bwr_ctrl  = bus_wr && (bus_addr == bcl_pkg::REG_CTRL);
  wire restart   = bwr_ctrl && bus_wdata[0] &&
                   (st_r == bcl_pkg::ST_FAIL);
  // Host port bytes count only while the failure loop runs
  wire hwr       = bus_wr && (bus_addr == bcl_pkg::REG_HCMD) &&
                   (st_r == bcl_pkg::ST_FAIL);
  wire [7:0] hb  = bus_wdata[7:0];
  wire rsp_rd    = bus_rd && (bus_addr == bcl_pkg::REG_HRSP);

  // ********************************************************
  // Boot sequence
  // ********************************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      bcl_pkg::ST_STRAP:
        if (strap_go) st_nxt = bcl_pkg::ST_CFG;
      bcl_pkg::ST_CFG:
        if (last) st_nxt = bcl_pkg::ST_CFG_CHK;
      bcl_pkg::ST_CFG_CHK:
        st_nxt = cfg_ok ? bcl_pkg::ST_LOAD : bcl_pkg::ST_FAIL;
      bcl_pkg::ST_LOAD:
        st_nxt = bcl_pkg::ST_HDR;
      bcl_pkg::ST_HDR:
        if (last) st_nxt = bcl_pkg::ST_HDR_CHK;
      bcl_pkg::ST_HDR_CHK:
        st_nxt = hdr_ok ? bcl_pkg::ST_SUM : bcl_pkg::ST_FAIL;
      bcl_pkg::ST_SUM:
        if (last) st_nxt = bcl_pkg::ST_SUM_CHK;
      bcl_pkg::ST_SUM_CHK: begin
        if (sum_r != 8'h00) st_nxt = bcl_pkg::ST_FAIL;
        else if (no_label) st_nxt = bcl_pkg::ST_BOOT;
        else st_nxt = bcl_pkg::ST_CRISIS;
      end
      bcl_pkg::ST_CRISIS:
        if (crisis_done)
          st_nxt = crisis_zero ? bcl_pkg::ST_BOOT
                               : bcl_pkg::ST_FAIL;
      bcl_pkg::ST_BOOT:
        st_nxt = bcl_pkg::ST_BOOT;
      bcl_pkg::ST_FAIL:
        if (restart) st_nxt = bcl_pkg::ST_STRAP;
      default:
        st_nxt = bcl_pkg::ST_FAIL;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r       <= bcl_pkg::ST_STRAP;
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
      wait_r     <= 2'h0;
      bus16_r    <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      strap_s1_r <= bus_width_strap_pin;
      strap_s2_r <= strap_s1_r;
      if (st_r != bcl_pkg::ST_STRAP) wait_r <= 2'h0;
      else if (!strap_go) wait_r <= wait_r + 2'h1;
      // Caught once the synchroniser holds a settled level
      if (strap_go) bus16_r <= strap_s2_r;
    end
  end

  // ********************************************************
  // Flash fetch and checksum
  // ********************************************************
  assign mem_rd_req  = fetching && !pend_r;
  assign mem_rd_addr = rd_addr_r;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_r    <= 1'b0;
      rd_addr_r <= 17'h00000;
      cnt_r     <= 17'h00000;
      sum_r     <= 8'h00;
      hdr_r     <= 64'h0;
    end else begin
      if (mem_rd_req) pend_r <= 1'b1;
      else if (take) pend_r <= 1'b0;
      if (strap_go) begin
        rd_addr_r <= bcl_pkg::CFG_BASE;
        cnt_r     <= bcl_pkg::CFG_COUNT;
      end else if (st_r == bcl_pkg::ST_LOAD) begin
        rd_addr_r <= {1'b0, w_hptr};
        cnt_r     <= bcl_pkg::HDR_COUNT;
        sum_r     <= 8'h00;
      end else if (st_r == bcl_pkg::ST_HDR_CHK) begin
        cnt_r     <= {1'b0, h_size, 8'h00};
      end else if (take) begin
        rd_addr_r <= rd_addr_r + 17'h00001;
        cnt_r     <= cnt_r - 17'h00001;
        // Config bytes never reach the sum
        if (st_r != bcl_pkg::ST_CFG)
          sum_r <= sum_r + mem_rsp.data;
        if (st_r == bcl_pkg::ST_HDR)
          hdr_r <= {hdr_r[55:0], mem_rsp.data};
      end
    end
  end

  // Plain storage, read only after a full fetch
  always_ff @(posedge ref_clk) begin
    if (take && (st_r == bcl_pkg::ST_CFG))
      cfg_mem[rd_addr_r[4:0]] <= mem_rsp.data;
  end

  // ********************************************************
  // Configuration registers and outcome
  // ********************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      module_config_reg_r        <= bcl_pkg::CFG_RST;
      busif_r       <= bcl_pkg::CFG_RST;
      ioz_r         <= bcl_pkg::CFG_RST;
      sz0_r         <= bcl_pkg::CFG_RST;
      bz_r          <= bcl_pkg::CFG_RST;
      pe_r          <= bcl_pkg::CFG_RST;
      page_r        <= bcl_pkg::CFG_RST;
      entry_r       <= 17'h00000;
      crisis_addr_r <= 17'h00000;
    end else if (st_r == bcl_pkg::ST_LOAD) begin
      module_config_reg_r  <= (w_module_config_reg & bcl_pkg::MODULE_CONFIG_REG_MASK) |
                 ({15'h0000, bus16_r} << bcl_pkg::MODULE_CONFIG_REG_BUS16);
      busif_r <= w_busif;
      ioz_r   <= w_ioz;
      pe_r    <= w_pe;
      page_r  <= w_page;
      sz0_r   <= w_sz0;
      sz0_r[bcl_pkg::ZONE_BW] <= bus16_r;
      bz_r    <= w_bz;
      bz_r[bcl_pkg::ZONE_BW]  <= 1'b1;
    end else if (st_r == bcl_pkg::ST_HDR_CHK) begin
      entry_r       <= {h_entry, 1'b0};
      crisis_addr_r <= {h_label, 1'b0};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fail_cfg_r    <= 1'b0;
      fail_fw_r     <= 1'b0;
      fail_crisis_r <= 1'b0;
      boot_ok_r     <= 1'b0;
      fw_start_r    <= 1'b0;
    end else begin
      boot_ok_r  <= (st_nxt == bcl_pkg::ST_BOOT);
      fw_start_r <= (st_nxt == bcl_pkg::ST_BOOT) &&
                    (st_r != bcl_pkg::ST_BOOT);
      if (restart) begin
        fail_cfg_r    <= 1'b0;
        fail_fw_r     <= 1'b0;
        fail_crisis_r <= 1'b0;
      end else if ((st_nxt == bcl_pkg::ST_FAIL) &&
                   (st_r != bcl_pkg::ST_FAIL)) begin
        fail_cfg_r    <= (st_r == bcl_pkg::ST_CFG_CHK);
        fail_fw_r     <= (st_r == bcl_pkg::ST_HDR_CHK) ||
                         (st_r == bcl_pkg::ST_SUM_CHK);
        fail_crisis_r <= (st_r == bcl_pkg::ST_CRISIS);
      end
    end
  end

  assign boot_ok_indicator_pin = boot_ok_r;
  assign fw_start      = fw_start_r;
  assign fw_entry_addr = entry_r;
  assign crisis_req    = (st_r == bcl_pkg::ST_CRISIS);
  assign crisis_addr   = crisis_addr_r;

  // ********************************************************
  // Recovery command service
  // ********************************************************
  wire [31:0] arg_nxt = {hb, arg_r[31:8]};
  wire [16:0] r_end   = {1'b0, arg_nxt[15:0]} +
                        {1'b0, arg_nxt[31:16]};
  // Variables, dispatch table and stacks stay out of reach
  wire perm = (arg_nxt[15:0] >= bcl_pkg::RAM_USER_LO) &&
              (r_end <= {1'b0, bcl_pkg::RAM_STK_LO});
  wire args_done = hwr && (cst_r == bcl_pkg::C_ARG) &&
                   (acnt_r == 2'h3);
  wire data_last = hwr && (cst_r == bcl_pkg::C_DATA) &&
                   (dcnt_r == 16'h0001);
  wire idle_cmd  = hwr && (cst_r == bcl_pkg::C_IDLE);
  wire [7:0] stat_b = {5'h00, fail_crisis_r, fail_fw_r, fail_cfg_r};

  wire rep_go = (idle_cmd && ((hb == bcl_pkg::CMD_TEST) ||
                              (hb == bcl_pkg::CMD_STAT))) ||
                (args_done && (arg_nxt[31:16] == 16'h0000)) ||
                data_last;
  wire rep_ok = args_done ? perm : ok_r;
  wire [7:0] rep_val =
    !idle_cmd ? (rep_ok ? bcl_pkg::RSP_ACK : bcl_pkg::RSP_ERR) :
    (hb == bcl_pkg::CMD_STAT) ? stat_b :
    bcl_pkg::RSP_ERR;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cst_r     <= bcl_pkg::C_IDLE;
      arg_r     <= 32'h0;
      acnt_r    <= 2'h0;
      dcnt_r    <= 16'h0000;
      ram_ptr_r <= 16'h0000;
      ok_r      <= 1'b0;
      ram_wr_r  <= '0;
    end else begin
      ram_wr_r.we <= 1'b0;
      if (st_r != bcl_pkg::ST_FAIL) cst_r <= bcl_pkg::C_IDLE;
      else if (hwr) begin
        case (cst_r)
          bcl_pkg::C_IDLE:
            if (hb == bcl_pkg::CMD_LOAD) begin
              cst_r  <= bcl_pkg::C_ARG;
              acnt_r <= 2'h0;
            end
          bcl_pkg::C_ARG: begin
            arg_r  <= arg_nxt;
            acnt_r <= acnt_r + 2'h1;
            if (args_done) begin
              ok_r      <= perm;
              ram_ptr_r <= arg_nxt[15:0];
              dcnt_r    <= arg_nxt[31:16];
              cst_r     <= (arg_nxt[31:16] == 16'h0000) ?
                           bcl_pkg::C_IDLE : bcl_pkg::C_DATA;
            end
          end
          bcl_pkg::C_DATA: begin
            // Refused data is drained but not written
            ram_wr_r.we   <= ok_r;
            ram_wr_r.addr <= ram_ptr_r;
            ram_wr_r.data <= hb;
            ram_ptr_r     <= ram_ptr_r + 16'h0001;
            dcnt_r        <= dcnt_r - 16'h0001;
            if (data_last) cst_r <= bcl_pkg::C_IDLE;
          end
          default:
            cst_r <= bcl_pkg::C_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resp_r   <= 8'h00;
      resp_v_r <= 1'b0;
    end else if (rep_go && (st_r == bcl_pkg::ST_FAIL)) begin
      resp_r   <= rep_val;
      resp_v_r <= 1'b1;
    end else if (rsp_rd) begin
      resp_v_r <= 1'b0;
    end
  end

  assign ram_wr = ram_wr_r;

  // ********************************************************
  // Register port
  // ********************************************************
  wire [15:0] rd_status = {7'h00, st_r, fail_crisis_r, fail_fw_r,
                           fail_cfg_r, bus16_r, boot_ok_r};
  wire [15:0] rd_mux =
    (bus_addr == bcl_pkg::REG_STATUS) ? rd_status :
    (bus_addr == bcl_pkg::REG_MODULE_CONFIG_REG)   ? module_config_reg_r :
    (bus_addr == bcl_pkg::REG_BUSIF)  ? busif_r :
    (bus_addr == bcl_pkg::REG_IOZ)    ? ioz_r :
    (bus_addr == bcl_pkg::REG_SZ0)    ? sz0_r :
    (bus_addr == bcl_pkg::REG_BZ)     ? bz_r :
    (bus_addr == bcl_pkg::REG_PE)     ? pe_r :
    (bus_addr == bcl_pkg::REG_PAGE)   ? page_r :
    (bus_addr == bcl_pkg::REG_HRSP)   ? {7'h00, resp_v_r, resp_r} :
    16'h0000;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) rdata_r <= 16'h0000;
    else rdata_r <= bus_rd ? rd_mux : 16'h0000;
  end

  assign bus_rdata = rdata_r;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_cfg_sig_fail: assert property (
    st_r == bcl_pkg::ST_CFG_CHK && !cfg_ok |=> st_r == bcl_pkg::ST_FAIL
  ) else $error("bad config signature not failed");

  a_cfg_window: assert property (
    mem_rd_req && st_r == bcl_pkg::ST_CFG |->
      mem_rd_addr >= 17'h00004 && mem_rd_addr <= 17'h0001F
  ) else $error("config read outside block");

  a_strap_width: assert property (
    st_r == bcl_pkg::ST_LOAD |=> sz0_r[bcl_pkg::ZONE_BW] == bus16_r
  ) else $error("static zone width not from strap");

  a_boot_zone16: assert property (
    st_r == bcl_pkg::ST_LOAD |=> bz_r[bcl_pkg::ZONE_BW]
  ) else $error("boot zone not 16-bit");

  a_module_config_reg_copy: assert property (
    st_r == bcl_pkg::ST_LOAD |=>
      (module_config_reg_r & bcl_pkg::MODULE_CONFIG_REG_MASK) == ($past(w_module_config_reg) & bcl_pkg::MODULE_CONFIG_REG_MASK)
  ) else $error("module config copy wrong");

  a_size_reject: assert property (
    st_r == bcl_pkg::ST_HDR_CHK && size_bad |=> st_r == bcl_pkg::ST_FAIL
  ) else $error("bad size accepted");

  a_sum_reject: assert property (
    st_r == bcl_pkg::ST_SUM_CHK && sum_r != 8'h00 |=> st_r == bcl_pkg::ST_FAIL
  ) else $error("nonzero checksum accepted");

  a_label_skip: assert property (
    st_r == bcl_pkg::ST_SUM_CHK && sum_r == 8'h00 && no_label |=>
      st_r == bcl_pkg::ST_BOOT ##1 boot_ok_indicator_pin
  ) else $error("absent routine not skipped");

  a_fail_pin_low: assert property (
    st_r == bcl_pkg::ST_FAIL |-> !boot_ok_indicator_pin
  ) else $error("indicator high while failing");

  a_self_test: assert property (
    idle_cmd && hb == bcl_pkg::CMD_TEST |=> resp_v_r && resp_r == 8'hFF
  ) else $error("self test not answered FFh");

endmodule

// File: bcl_flash_model.sv
// Purpose: Flash model answering byte reads of the loader
// Assumes: One read outstanding at a time; contents set by the bench
// Notes:   Odd addresses answer two cycles slower than even ones
`timescale 1ns/100ps
// ********************************************************
// Flash model
// ********************************************************
module bcl_flash_model (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic                mem_rd_req,
  input  wire logic [16:0]         mem_rd_addr,
  output bcl_pkg::bcl_mem_rsp_type mem_rsp
);
  logic [7:0] mem [0:1023];
  logic       busy_r;
  logic [1:0] wait_r;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_rsp <= '0;
      busy_r  <= 1'b0;
      wait_r  <= 2'h0;
    end else begin
      mem_rsp.valid <= 1'b0;
      mem_rsp.data  <= ~mem_rsp.data; // Idle bus flips the last byte each cycle, so it shows again every other cycle
      if (mem_rd_req) begin
        busy_r <= 1'b1;
        wait_r <= {mem_rd_addr[0], 1'b0};
      end else if (busy_r && wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end else if (busy_r) begin
        busy_r  <= 1'b0;
        mem_rsp <= {1'b1, mem[mem_rd_addr[9:0]]};
      end
    end
  end
endmodule

// File: boot_config_loader_test.sv
// Purpose: Bench for the loader: config fail, header fail, good boot
// Assumes: Flash image patched between runs; one reset in mid-run
// Notes:   The first two restarts from the failure state follow a flash patch, the last a crisis_zero change
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module boot_config_loader_test;
  logic ref_clk = 1'b0, sys_rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [7:0] bus_addr = 8'h00, sum;
  logic [15:0] bus_wdata = 16'h0000, bus_rdata, v;
  logic mem_rd_req, pin, fw_start, crisis_req, strap = 1'b1;
  logic crisis_done = 1'b0, crisis_zero = 1'b0;
  logic [16:0] mem_rd_addr, fw_entry_addr, crisis_addr;
  bcl_pkg::bcl_mem_rsp_type mem_rsp;
  bcl_pkg::bcl_ram_wr_type ram_wr, wlast;
  int failures = 0, total_checks = 0, cyc = 0, starts = 0, wcnt = 0;
  bcl_boot_config_loader dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rsp(mem_rsp),
    .bus_width_strap_pin(strap), .boot_ok_indicator_pin(pin), .crisis_req(crisis_req),
    .crisis_addr(crisis_addr), .crisis_done(crisis_done), .crisis_zero(crisis_zero),
    .fw_entry_addr(fw_entry_addr), .fw_start(fw_start), .ram_wr(ram_wr));
  bcl_flash_model flash (.ref_clk(ref_clk), .sys_rst(sys_rst), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rsp(mem_rsp));
  initial forever #25 ref_clk = ~ref_clk;
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (fw_start === 1'b1) starts++;
    if (ram_wr.we === 1'b1) begin
      wcnt++;
      wlast = ram_wr;
    end
    // Stand-in routine: one done pulse per request
    crisis_done <= (crisis_req === 1'b1) && !crisis_done;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk) begin bus_wr <= 1'b1; bus_addr <= a; bus_wdata <= d; end
    @(posedge ref_clk) bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk) begin bus_rd <= 1'b1; bus_addr <= a; end
    @(posedge ref_clk) bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic settle();
    v = 16'h0000;
    for (int i = 0; i < 2000 && v[8:5] < 4'h9; i++) rd(bcl_pkg::REG_STATUS, v);
  endtask
  task automatic seal();
    sum = 8'h00;
    for (int i = 32; i < 296; i++) if (i != 35) sum += flash.mem[i];
    flash.mem[35] = -sum;
  endtask
  task automatic host(input logic [55:0] s, input int n);
    for (int i = n - 1; i >= 0; i--) wr(bcl_pkg::REG_HCMD, {8'h00, s[8*i +: 8]});
  endtask
  initial begin
    for (int i = 0; i < 1024; i++) flash.mem[i] = 8'(i);
    {flash.mem[4], flash.mem[5], flash.mem[6], flash.mem[7]} = 32'hE38E1C00;
    flash.mem[8] = 8'h16;
    {flash.mem[13], flash.mem[12], flash.mem[15], flash.mem[14]} = 32'h0020FFFF;
    {flash.mem[33], flash.mem[32], flash.mem[34]} = 24'hCC33FF;
    {flash.mem[37], flash.mem[36], flash.mem[39], flash.mem[38]} = 32'hFFFF0150;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    settle();
    `CHK(v[8:2], 7'h51)
    `CHK(pin, 1'b0)
    wr(bcl_pkg::REG_HCMD, 16'h00AA);
    rd(bcl_pkg::REG_HRSP, v);
    `CHK(v, 16'h01FF)
    flash.mem[7] = 8'h71;
    wr(bcl_pkg::REG_CTRL, 16'h0001);
    settle();
    `CHK(v[8:2], 7'h52)
    flash.mem[34] = 8'h01;
    seal();
    wr(bcl_pkg::REG_CTRL, 16'h0001);
    settle();
    `CHK(v, 16'h0123)
    `CHK(pin, 1'b1)
    `CHK(fw_entry_addr, 17'h002A0)
    rd(bcl_pkg::REG_MODULE_CONFIG_REG, v);
    `CHK(v, 16'h000F)
    rd(bcl_pkg::REG_BUSIF, v);
    `CHK(v, 16'h1110)
    rd(bcl_pkg::REG_SZ0, v);
    `CHK(v, 16'h1594)
    rd(bcl_pkg::REG_BZ, v);
    `CHK(v, 16'h1796)
    rd(bcl_pkg::REG_PAGE, v);
    `CHK(v, 16'h0B0A)
    rd(bcl_pkg::REG_IOZ, v);
    `CHK(v, 16'h1312)
    rd(bcl_pkg::REG_PE, v);
    `CHK(v, 16'h1918)
    `CHK(starts, 1)
    {flash.mem[37], flash.mem[36]} = 16'h0140;
    seal();
    strap <= 1'b0;
    @(posedge ref_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(bcl_pkg::REG_STATUS, v);
    `CHK(v, 16'h0000)
    settle();
    `CHK(v[8:1], 8'hA8)
    `CHK(crisis_addr, 17'h00280)
    rd(bcl_pkg::REG_SZ0, v);
    `CHK(v, 16'h1514)
    rd(bcl_pkg::REG_MODULE_CONFIG_REG, v);
    `CHK(v, 16'h0007)
    wr(bcl_pkg::REG_HCMD, 16'h0092);
    rd(bcl_pkg::REG_HRSP, v);
    `CHK(v, 16'h0104)
    host(56'h9070F00200ABCD, 7);
    rd(bcl_pkg::REG_HRSP, v);
    `CHK(v, 16'h01FA)
    `CHK(wcnt, 2)
    `CHK(wlast, 25'h1F071CD)
    host(56'h9000F0010055, 6);
    rd(bcl_pkg::REG_HRSP, v);
    `CHK(v, 16'h01FF)
    `CHK(wcnt, 2)
    crisis_zero <= 1'b1;
    wr(bcl_pkg::REG_CTRL, 16'h0001);
    settle();
    `CHK(v, 16'h0121)
    `CHK(starts, 2)
    `CHK(pin, 1'b1)
    tally_and_finish();
  end
endmodule
